// ---- src/mcs_pkg.sv ----
// Constants shared by the host end and the module end of the control link.
// Assumes a 40 MHz host clock (mclk) and an 80 ns link clock at the module.
// Contract
// - Hard disable turns laser off promptly
// - Hard enable restores laser output promptly
// - Initialisation completes within 300 ms
// - Fault output asserts within 1000 us
// - Host holds disable 10 us to reset
// - Host spaces disable assertions by 10 ms
// - Loss output asserts within 100 us
// - Loss output clears within 100 us
// - Loss tracks modulated amplitude only
// - Soft disable bit stops laser quickly
// - Clearing soft disable restores laser output
// - Soft fault bit follows fault
// - Soft loss bit follows loss
// - Data-ready bit set within 1000 ms
// - Both bus addresses answer within 300 ms
// - Writes up to 4 bytes finish in 40 ms
// - Writes of 5-8 bytes finish in 80 ms
// - Bus clock at most 400 kHz, stretching honoured
// - Host leaves bus free 20 us
package mcs_pkg;
	// Clock periods
	localparam int LINK_NS = 80;
	localparam int MCLK_NS = 25;
	// Module-side times and counts on the link clock
	localparam int T_INIT_MS = 300;
	localparam int INIT_CYC = T_INIT_MS * 1000000 / LINK_NS;
	localparam int T_DATA_MS = 1000;
	localparam int DATA_CYC = T_DATA_MS * 1000000 / LINK_NS;
	localparam int T_WR4_MS = 40;
	localparam int WR4_CYC = T_WR4_MS * 1000000 / LINK_NS;
	localparam int T_WR8_MS = 80;
	localparam int WR8_CYC = T_WR8_MS * 1000000 / LINK_NS;
	localparam int T_RESET_US = 10;
	localparam logic [31:0] DEV_RESET_CYC = 32'(T_RESET_US * 1000 / LINK_NS);
	localparam logic [3:0] WR_SHORT_MAX = 4'h4;
	// Host-side times and counts on mclk
	localparam int HOST_HOLD_CYC = (T_RESET_US * 1000 + MCLK_NS - 1) / MCLK_NS;
	localparam int T_GAP_MS = 10;
	localparam int GAP_CYC = T_GAP_MS * 1000000 / MCLK_NS;
	localparam int T_BUF_US = 20;
	localparam int BUF_CYC = (T_BUF_US * 1000 + MCLK_NS - 1) / MCLK_NS;
	localparam int SCL_MAX_KHZ = 400;
	localparam int QTR_CYC = (1000000 / SCL_MAX_KHZ / 4 + MCLK_NS - 1) / MCLK_NS;
	// Bus addresses and the control/status byte
	localparam logic [6:0] ID_ADDR = 7'h50;
	localparam logic [6:0] DIAG_ADDR = 7'h51;
	localparam logic [7:0] CSB_OFF = 8'h6E;
	localparam logic [7:0] CSB_RESET = 8'h00;
	localparam int CSB_SOFTDIS = 6;
	localparam int CSB_FAULT = 2;
	localparam int CSB_LOS = 1;
	localparam int CSB_RDY = 0;
endpackage : mcs_pkg

// ---- src/mcs_link_if.sv ----
// Pins between host board and module: disable, fault, loss and the two-wire bus.
// Open-drain wires resolve here with an implied pull-up.
`timescale 1ns/10ps
interface mcs_link_if;
	logic txDisable;
	logic txFault;
	logic rxLos;
	logic sclOutH;
	logic sclOeH;
	logic sdaOutH;
	logic sdaOeH;
	logic sdaOutD;
	logic sdaOeD;
	logic scl;
	logic sda;
	assign scl = (sclOeH & ~sclOutH) ? 1'b0 : 1'b1;
	assign sda = ((sdaOeH & ~sdaOutH) | (sdaOeD & ~sdaOutD)) ? 1'b0 : 1'b1;
	modport host(output txDisable, output sclOutH, output sclOeH, output sdaOutH,
		output sdaOeH, input txFault, input rxLos, input scl, input sda);
	modport dev(input txDisable, input scl, input sda, output txFault, output rxLos,
		output sdaOutD, output sdaOeD);
endinterface : mcs_link_if

// ---- src/mcs_module_end.sv ----
// Module end: laser control, fault latch, loss flag and two-wire slave.
// Runs on the link clock; every pin and user input is synchronised first.
`timescale 1ns/10ps
module mcs_module_end #(
	parameter int INIT_CYC = mcs_pkg::INIT_CYC,
	parameter int DATA_CYC = mcs_pkg::DATA_CYC,
	parameter int WR4_CYC = mcs_pkg::WR4_CYC,
	parameter int WR8_CYC = mcs_pkg::WR8_CYC
) (
	input wire logic linkClk,
	input wire logic rst_n,
	mcs_link_if.dev lnk,
	input wire logic laserFault,
	input wire logic sigPresent,
	output logic laserOn_ff
);
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_PTR, S_WR, S_RD} mcs_sst_t;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	localparam int NSYNC = 5;
	// Bus lines rest high, so their chains start high to avoid a false edge
	localparam logic [NSYNC-1:0] SYNC_IDLE = 5'h06;
	logic [NSYNC-1:0] rawIn;
	logic [NSYNC-1:0] syncA_ff;
	logic [NSYNC-1:0] syncB_ff;
	assign rawIn = {sigPresent, laserFault, lnk.sda, lnk.scl, lnk.txDisable};

	generate
		for (genvar i = 0; i < NSYNC; i++) begin : g_sync
			always_ff @(posedge linkClk or negedge rst_n) begin
				if (!rst_n) begin
					syncA_ff[i] <= SYNC_IDLE[i];
					syncB_ff[i] <= SYNC_IDLE[i];
				end else begin
					syncA_ff[i] <= rawIn[i];
					syncB_ff[i] <= syncA_ff[i];
				end
			end
		end
	endgenerate

	logic disS;
	logic sclS;
	logic sdaS;
	logic faultS;
	logic sigS;
	assign disS = syncB_ff[0];
	assign sclS = syncB_ff[1];
	assign sdaS = syncB_ff[2];
	assign faultS = syncB_ff[3];
	assign sigS = syncB_ff[4];

	// ------------------------------------------------------------
	// Power-on timers
	// ------------------------------------------------------------
	logic [31:0] initCnt_ff;
	logic [31:0] dataCnt_ff;
	logic ready_ff;
	logic dataRdy_ff;

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			initCnt_ff <= '0;
			ready_ff <= 1'b0;
		end else if (!ready_ff) begin
			if (initCnt_ff == 32'(INIT_CYC - 1)) begin
				ready_ff <= 1'b1;
			end else begin
				initCnt_ff <= initCnt_ff + 32'h1;
			end
		end
	end

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			dataCnt_ff <= '0;
			dataRdy_ff <= 1'b0;
		end else if (!dataRdy_ff) begin
			if (dataCnt_ff == 32'(DATA_CYC - 1)) begin
				dataRdy_ff <= 1'b1;
			end else begin
				dataCnt_ff <= dataCnt_ff + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Fault latch, loss flag, laser drive
	// ------------------------------------------------------------
	logic [31:0] holdCnt_ff;
	logic faultLat_ff;
	logic rxLos_ff;
	logic softDis_ff;

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			holdCnt_ff <= '0;
		end else if (!disS) begin
			holdCnt_ff <= '0;
		end else if (holdCnt_ff != mcs_pkg::DEV_RESET_CYC) begin
			holdCnt_ff <= holdCnt_ff + 32'h1;
		end
	end

	// Set wins over the disable-pin clear
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			faultLat_ff <= 1'b0;
		end else if (faultS && ready_ff) begin
			faultLat_ff <= 1'b1;
		end else if (holdCnt_ff == mcs_pkg::DEV_RESET_CYC) begin
			faultLat_ff <= 1'b0;
		end
	end

	// Detector reports modulated amplitude; plain light gives no defined answer
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			rxLos_ff <= 1'b1;
		end else begin
			rxLos_ff <= ~sigS;
		end
	end

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			laserOn_ff <= 1'b0;
		end else begin
			laserOn_ff <= ready_ff & ~(disS | softDis_ff) & ~faultLat_ff;
		end
	end

	assign lnk.txFault = faultLat_ff;
	assign lnk.rxLos = rxLos_ff;

	// ------------------------------------------------------------
	// Two-wire slave
	// ------------------------------------------------------------
	logic sclP_ff;
	logic sdaP_ff;
	logic startEv;
	logic stopEv;
	logic sclRise;
	logic sclFall;
	logic [7:0] statusByte;
	logic [7:0] shift_ff;
	logic [7:0] txByte_ff;
	logic [7:0] ptr_ff;
	logic [7:0] rb;
	logic [3:0] bitCnt_ff;
	logic [3:0] wrBytes_ff;
	logic [31:0] busyCnt_ff;
	logic sdaOe_ff;
	logic mAck_ff;
	logic isDiag_ff;
	logic pendVal_ff;
	logic pendDis_ff;
	logic addrHit;
	mcs_sst_t st_ff;

	function automatic logic [7:0] readByte(input logic diag, input logic [7:0] addr,
		input logic [7:0] stat);
		return (diag && addr == mcs_pkg::CSB_OFF) ? stat : mcs_pkg::CSB_RESET;
	endfunction : readByte

	always_comb begin
		statusByte = mcs_pkg::CSB_RESET;
		statusByte[mcs_pkg::CSB_SOFTDIS] = softDis_ff;
		statusByte[mcs_pkg::CSB_FAULT] = faultLat_ff;
		statusByte[mcs_pkg::CSB_LOS] = rxLos_ff;
		statusByte[mcs_pkg::CSB_RDY] = dataRdy_ff;
	end

	assign startEv = sclS & sclP_ff & sdaP_ff & ~sdaS;
	assign stopEv = sclS & sclP_ff & ~sdaP_ff & sdaS;
	assign sclRise = sclS & ~sclP_ff;
	assign sclFall = ~sclS & sclP_ff;
	assign addrHit = (busyCnt_ff == 32'h0) && (shift_ff[7:1] == mcs_pkg::DIAG_ADDR ||
		shift_ff[7:1] == mcs_pkg::ID_ADDR);
	assign rb = readByte(isDiag_ff, ptr_ff, statusByte);

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			sclP_ff <= 1'b1;
			sdaP_ff <= 1'b1;
		end else begin
			sclP_ff <= sclS;
			sdaP_ff <= sdaS;
		end
	end

	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= S_IDLE;
			bitCnt_ff <= '0;
			shift_ff <= '0;
			txByte_ff <= '0;
			ptr_ff <= '0;
			sdaOe_ff <= 1'b0;
			mAck_ff <= 1'b0;
			isDiag_ff <= 1'b0;
			wrBytes_ff <= '0;
			pendVal_ff <= 1'b0;
			pendDis_ff <= 1'b0;
		end else if (stopEv) begin
			st_ff <= S_IDLE;
			sdaOe_ff <= 1'b0;
			wrBytes_ff <= '0;
			pendVal_ff <= 1'b0;
		end else if (startEv && ready_ff) begin
			st_ff <= S_ADDR;
			bitCnt_ff <= '0;
			sdaOe_ff <= 1'b0;
		end else if (st_ff != S_IDLE) begin
			if (sclRise) begin
				if (bitCnt_ff < 4'h8) begin
					shift_ff <= {shift_ff[6:0], sdaS};
					bitCnt_ff <= bitCnt_ff + 4'h1;
				end else begin
					mAck_ff <= ~sdaS;
					bitCnt_ff <= 4'h9;
				end
			end else if (sclFall) begin
				// Fall with no bit counted is the one after a start
				if (bitCnt_ff != 4'h0 && bitCnt_ff < 4'h8) begin
					if (st_ff == S_RD) begin
						sdaOe_ff <= ~txByte_ff[6];
						txByte_ff <= {txByte_ff[6:0], 1'b0};
					end
				end else if (bitCnt_ff == 4'h8) begin
					sdaOe_ff <= 1'b0;
					case (st_ff)
						S_ADDR: begin
							if (addrHit) begin
								sdaOe_ff <= 1'b1;
								isDiag_ff <= (shift_ff[7:1] == mcs_pkg::DIAG_ADDR);
								st_ff <= shift_ff[0] ? S_RD : S_PTR;
							end else begin
								st_ff <= S_IDLE;
							end
						end
						S_PTR: begin
							sdaOe_ff <= 1'b1;
							ptr_ff <= shift_ff;
							st_ff <= S_WR;
						end
						S_WR: begin
							sdaOe_ff <= 1'b1;
							ptr_ff <= ptr_ff + 8'h1;
							if (wrBytes_ff != 4'hF) begin
								wrBytes_ff <= wrBytes_ff + 4'h1;
							end
							if (isDiag_ff && ptr_ff == mcs_pkg::CSB_OFF) begin
								pendVal_ff <= 1'b1;
								pendDis_ff <= shift_ff[mcs_pkg::CSB_SOFTDIS];
							end
						end
						default: begin
							sdaOe_ff <= 1'b0;
						end
					endcase
				end else if (bitCnt_ff == 4'h9) begin
					bitCnt_ff <= '0;
					sdaOe_ff <= 1'b0;
					if (st_ff == S_RD) begin
						if (mAck_ff) begin
							txByte_ff <= rb;
							sdaOe_ff <= ~rb[7];
							ptr_ff <= ptr_ff + 8'h1;
						end else begin
							st_ff <= S_IDLE;
						end
					end
				end
			end
		end
	end

	// Soft disable takes effect at the stop that ends the write
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			softDis_ff <= mcs_pkg::CSB_RESET[mcs_pkg::CSB_SOFTDIS];
		end else if (stopEv && pendVal_ff) begin
			softDis_ff <= pendDis_ff;
		end
	end

	// Write cycle: address is not acknowledged until it ends
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) begin
			busyCnt_ff <= '0;
		end else if (stopEv && wrBytes_ff != 4'h0) begin
			busyCnt_ff <= (wrBytes_ff > mcs_pkg::WR_SHORT_MAX) ? 32'(WR8_CYC - 1)
				: 32'(WR4_CYC - 1);
		end else if (busyCnt_ff != 32'h0) begin
			busyCnt_ff <= busyCnt_ff - 32'h1;
		end
	end

	// Module never stretches the clock
	assign lnk.sdaOutD = 1'b0;
	assign lnk.sdaOeD = sdaOe_ff;
endmodule : mcs_module_end

// ---- src/mcs_host_end.sv ----
// Host end: drives the disable pin and masters the two-wire bus.
// Runs on mclk; pins from the module are synchronised first.
`timescale 1ns/10ps
module mcs_host_end #(
	parameter int GAP_CYC = mcs_pkg::GAP_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	mcs_link_if.host lnk,
	input wire logic hwDisable,
	input wire logic cmdValid,
	input wire logic cmdRead,
	input wire logic [6:0] cmdDev,
	input wire logic [7:0] cmdPtr,
	input wire logic [7:0] cmdData,
	output logic busy_ff,
	output logic done_ff,
	output logic ackErr_ff,
	output logic [7:0] rdData_ff,
	output logic modFault_ff,
	output logic modLos_ff
);
	typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_STOP, M_FREE} mcs_mst_t;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [3:0] rawIn;
	logic [3:0] syncA_ff;
	logic [3:0] syncB_ff;
	assign rawIn = {lnk.sda, lnk.scl, lnk.rxLos, lnk.txFault};

	generate
		for (genvar i = 0; i < 4; i++) begin : g_sync
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					syncA_ff[i] <= 1'b0;
					syncB_ff[i] <= 1'b0;
				end else begin
					syncA_ff[i] <= rawIn[i];
					syncB_ff[i] <= syncA_ff[i];
				end
			end
		end
	endgenerate

	assign modFault_ff = syncB_ff[0];
	assign modLos_ff = syncB_ff[1];

	// ------------------------------------------------------------
	// Disable pin pacing
	// ------------------------------------------------------------
	logic txDis_ff;
	logic [31:0] holdCnt_ff;
	logic [31:0] gapCnt_ff;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txDis_ff <= 1'b0;
			holdCnt_ff <= '0;
			gapCnt_ff <= 32'(GAP_CYC);
		end else begin
			if (gapCnt_ff != 32'(GAP_CYC)) begin
				gapCnt_ff <= gapCnt_ff + 32'h1;
			end
			if (holdCnt_ff != 32'(mcs_pkg::HOST_HOLD_CYC)) begin
				holdCnt_ff <= holdCnt_ff + 32'h1;
			end
			if (!txDis_ff && hwDisable && gapCnt_ff == 32'(GAP_CYC)) begin
				txDis_ff <= 1'b1;
				gapCnt_ff <= '0;
				holdCnt_ff <= '0;
			end else if (txDis_ff && !hwDisable &&
				holdCnt_ff == 32'(mcs_pkg::HOST_HOLD_CYC)) begin
				txDis_ff <= 1'b0;
			end
		end
	end

	assign lnk.txDisable = txDis_ff;

	// ------------------------------------------------------------
	// Two-wire master
	// ------------------------------------------------------------
	mcs_mst_t st_ff;
	logic [7:0] qCnt_ff;
	logic [15:0] bufCnt_ff;
	logic [1:0] ph_ff;
	logic [1:0] step_ff;
	logic [3:0] bit_ff;
	logic [7:0] shift_ff;
	logic [6:0] dev_ff;
	logic [7:0] ptr_ff;
	logic [7:0] wd_ff;
	logic rd_ff;
	logic nack_ff;
	logic sclOe_ff;
	logic sdaOe_ff;
	logic tick;
	logic isRx;
	logic [7:0] curByte;

	function automatic logic [7:0] txSel(input logic [1:0] step, input logic rd,
		input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] wd);
		case (step)
			2'h0: return {dev, 1'b0};
			2'h1: return ptr;
			2'h2: return rd ? {dev, 1'b1} : wd;
			default: return 8'hFF;
		endcase
	endfunction : txSel

	assign tick = (qCnt_ff == 8'(mcs_pkg::QTR_CYC - 1));
	assign isRx = rd_ff && step_ff == 2'h3;
	assign curByte = txSel(step_ff, rd_ff, dev_ff, ptr_ff, wd_ff);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			qCnt_ff <= '0;
		end else begin
			qCnt_ff <= tick ? 8'h0 : qCnt_ff + 8'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= M_IDLE;
			ph_ff <= '0;
			step_ff <= '0;
			bit_ff <= '0;
			shift_ff <= '0;
			dev_ff <= '0;
			ptr_ff <= '0;
			wd_ff <= '0;
			rd_ff <= 1'b0;
			nack_ff <= 1'b0;
			sclOe_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			ackErr_ff <= 1'b0;
			rdData_ff <= '0;
			bufCnt_ff <= '0;
		end else begin
			done_ff <= 1'b0;
			case (st_ff)
				M_IDLE: begin
					if (cmdValid) begin
						st_ff <= M_START;
						busy_ff <= 1'b1;
						ph_ff <= '0;
						step_ff <= '0;
						rd_ff <= cmdRead;
						dev_ff <= cmdDev;
						ptr_ff <= cmdPtr;
						wd_ff <= cmdData;
						ackErr_ff <= 1'b0;
					end
				end
				M_START: begin
					if (tick) begin
						case (ph_ff)
							2'h0: sdaOe_ff <= 1'b0;
							2'h1: sclOe_ff <= 1'b0;
							2'h2: sdaOe_ff <= syncB_ff[2];
							default: begin
								sclOe_ff <= 1'b1;
								st_ff <= M_BIT;
								bit_ff <= '0;
							end
						endcase
						if (ph_ff != 2'h2 || syncB_ff[2]) begin
							ph_ff <= ph_ff + 2'h1;
						end
					end
				end
				M_BIT: begin
					if (tick) begin
						case (ph_ff)
							2'h0: sdaOe_ff <= (isRx || bit_ff == 4'h8) ? 1'b0
								: ~curByte[3'(4'h7 - bit_ff)];
							2'h1: sclOe_ff <= 1'b0;
							2'h2: begin
								if (syncB_ff[2] && bit_ff < 4'h8) begin
									shift_ff <= {shift_ff[6:0], syncB_ff[3]};
								end else if (syncB_ff[2]) begin
									nack_ff <= syncB_ff[3];
								end
							end
							default: begin
								sclOe_ff <= 1'b1;
								bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
								if (bit_ff == 4'h8) begin
									if (!isRx && nack_ff) begin
										ackErr_ff <= 1'b1;
										st_ff <= M_STOP;
									end else if (isRx) begin
										rdData_ff <= shift_ff;
										st_ff <= M_STOP;
									end else if (step_ff == 2'h1 && rd_ff) begin
										step_ff <= 2'h2;
										st_ff <= M_START;
									end else if (step_ff == 2'h2 && !rd_ff) begin
										st_ff <= M_STOP;
									end else begin
										step_ff <= step_ff + 2'h1;
									end
								end
							end
						endcase
						if (ph_ff != 2'h2 || syncB_ff[2]) begin
							ph_ff <= ph_ff + 2'h1;
						end
					end
				end
				M_STOP: begin
					if (tick) begin
						case (ph_ff)
							2'h0: sdaOe_ff <= 1'b1;
							2'h1: sclOe_ff <= 1'b0;
							default: begin
								if (syncB_ff[2]) begin
									sdaOe_ff <= 1'b0;
									st_ff <= M_FREE;
									bufCnt_ff <= '0;
								end
							end
						endcase
						if (ph_ff < 2'h2) begin
							ph_ff <= ph_ff + 2'h1;
						end else if (syncB_ff[2]) begin
							ph_ff <= '0;
						end
					end
				end
				M_FREE: begin
					if (bufCnt_ff == 16'(mcs_pkg::BUF_CYC - 1)) begin
						st_ff <= M_IDLE;
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end else begin
						bufCnt_ff <= bufCnt_ff + 16'h1;
					end
				end
				default: st_ff <= M_IDLE;
			endcase
		end
	end

	assign lnk.sclOutH = 1'b0;
	assign lnk.sclOeH = sclOe_ff;
	assign lnk.sdaOutH = 1'b0;
	assign lnk.sdaOeH = sdaOe_ff;
endmodule : mcs_host_end

// ---- src/mcs_host_end_fix.sv ----
// Spare source file: holds no logic.

// ---- test/mcs_link_checker.sv ----
// Checker: timing properties on the link signals between host end and module end.
// Assumes the bench instantiates it beside the link interface with matching parameters.
`timescale 1ns/10ps
module mcs_link_checker #(
	parameter int INIT_CYC = mcs_pkg::INIT_CYC,
	parameter int GAP_CYC = mcs_pkg::GAP_CYC
) (
	input wire logic mclk,
	input wire logic linkClk,
	input wire logic rst_n,
	input wire logic txDisable,
	input wire logic txFault,
	input wire logic rxLos,
	input wire logic sclOutH,
	input wire logic sclOeH,
	input wire logic sdaOutH,
	input wire logic sdaOeH,
	input wire logic sdaOutD,
	input wire logic sdaOeD,
	input wire logic scl,
	input wire logic sda
);
	localparam int START_MAX = 2 * mcs_pkg::QTR_CYC;
	localparam logic [31:0] SAT = 32'h00FFFFFF;
	logic [31:0] gapCnt_ff;
	logic [31:0] holdCnt_ff;
	logic [31:0] sclCnt_ff;
	logic [31:0] bufCnt_ff;
	logic [31:0] initCnt_ff;
	logic [31:0] disHiCnt_ff;
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) gapCnt_ff <= SAT;
		else if ($rose(txDisable)) gapCnt_ff <= 32'h0;
		else if (gapCnt_ff < SAT) gapCnt_ff <= gapCnt_ff + 32'h1;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) holdCnt_ff <= 32'h0;
		else if ($rose(txDisable)) holdCnt_ff <= 32'h0;
		else if (txDisable && holdCnt_ff < SAT) holdCnt_ff <= holdCnt_ff + 32'h1;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) sclCnt_ff <= SAT;
		else if ($rose(scl)) sclCnt_ff <= 32'h0;
		else if (sclCnt_ff < SAT) sclCnt_ff <= sclCnt_ff + 32'h1;
	end
	// Counts from the last stop condition
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) bufCnt_ff <= SAT;
		else if (scl && $rose(sda)) bufCnt_ff <= 32'h0;
		else if (bufCnt_ff < SAT) bufCnt_ff <= bufCnt_ff + 32'h1;
	end
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) initCnt_ff <= 32'h0;
		else if (initCnt_ff < SAT) initCnt_ff <= initCnt_ff + 32'h1;
	end
	// Length of the latest high run of the disable pin
	always_ff @(posedge linkClk or negedge rst_n) begin
		if (!rst_n) disHiCnt_ff <= 32'h0;
		else if ($rose(txDisable)) disHiCnt_ff <= 32'h1;
		else if (txDisable && disHiCnt_ff < SAT) disHiCnt_ff <= disHiCnt_ff + 32'h1;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_dis_gap: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(txDisable) |-> gapCnt_ff >= GAP_CYC - 1)
		else $error("Disable pin raised inside the spacing gap");
	a_dis_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(txDisable) |-> holdCnt_ff >= mcs_pkg::HOST_HOLD_CYC - 1)
		else $error("Disable pin pulse too short");
	a_bus_free: assert property (@(posedge mclk) disable iff (!rst_n)
		(scl && $fell(sda)) |-> bufCnt_ff >= mcs_pkg::BUF_CYC - 1)
		else $error("Start came too soon after stop");
	a_scl_rate: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(scl) |-> sclCnt_ff >= 4 * mcs_pkg::QTR_CYC - 1)
		else $error("Bus clock too fast");
	a_start_form: assert property (@(posedge mclk) disable iff (!rst_n)
		(scl && $fell(sda)) |-> ##[1:START_MAX] (!scl && !sda))
		else $error("Start not followed by clock low");
	a_dev_ready: assert property (@(posedge linkClk) disable iff (!rst_n)
		sdaOeD |-> initCnt_ff >= INIT_CYC)
		else $error("Module drove the bus before ready");
	a_fault_ready: assert property (@(posedge linkClk) disable iff (!rst_n)
		$rose(txFault) |-> initCnt_ff >= INIT_CYC)
		else $error("Fault raised during initialisation");
	a_fault_clear: assert property (@(posedge linkClk) disable iff (!rst_n)
		$fell(txFault) |-> disHiCnt_ff >= mcs_pkg::DEV_RESET_CYC - 32'h1)
		else $error("Fault cleared without a long enough disable");
	a_dev_sda_low: assert property (@(posedge linkClk) disable iff (!rst_n)
		$changed(sdaOeD) |-> !scl)
		else $error("Module changed data while clock high");
endmodule : mcs_link_checker

// ---- test/module_control_status_timing_tb.sv ----
// Testbench: host end and module end joined by the link interface, with checker.
// Assumes the design under src/ and shortened counts passed as parameters.
`timescale 1ns/10ps
module module_control_status_timing_tb;
	localparam int INIT_T = 2000;
	localparam int GAP_T = 1000;
	localparam logic [6:0] DIA = mcs_pkg::DIAG_ADDR;
	localparam logic [7:0] CSB = mcs_pkg::CSB_OFF;
	logic mclk = 1'b0;
	logic linkClk = 1'b0;
	logic rst_n = 1'b0;
	logic hwDisable = 1'b0;
	logic cmdValid = 1'b0;
	logic cmdRead = 1'b0;
	logic [6:0] cmdDev = 7'h00;
	logic [7:0] cmdPtr = 8'h00;
	logic [7:0] cmdData = 8'h00;
	logic laserFault = 1'b0;
	logic sigPresent = 1'b1;
	logic laserOn, busy, done, ackErr, modFault, modLos;
	logic [7:0] rdData;
	int miscompares = 0;
	int cmp_count = 0;
	mcs_link_if lnk();
	always #12.5 mclk = ~mclk;
	initial begin
		#7;
		forever #40 linkClk = ~linkClk;
	end
	mcs_host_end #(.GAP_CYC(GAP_T)) i_mcs_host_end (.mclk(mclk), .rst_n(rst_n), .lnk(lnk.host),
		.hwDisable(hwDisable), .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdDev(cmdDev),
		.cmdPtr(cmdPtr), .cmdData(cmdData), .busy_ff(busy), .done_ff(done), .ackErr_ff(ackErr),
		.rdData_ff(rdData), .modFault_ff(modFault), .modLos_ff(modLos));
	mcs_module_end #(.INIT_CYC(INIT_T), .DATA_CYC(4000), .WR4_CYC(50), .WR8_CYC(100))
		i_mcs_module_end (.linkClk(linkClk), .rst_n(rst_n), .lnk(lnk.dev),
		.laserFault(laserFault), .sigPresent(sigPresent), .laserOn_ff(laserOn));
	mcs_link_checker #(.INIT_CYC(INIT_T), .GAP_CYC(GAP_T)) i_mcs_link_checker (.mclk(mclk),
		.linkClk(linkClk), .rst_n(rst_n), .txDisable(lnk.txDisable), .txFault(lnk.txFault),
		.rxLos(lnk.rxLos), .sclOutH(lnk.sclOutH), .sclOeH(lnk.sclOeH), .sdaOutH(lnk.sdaOutH),
		.sdaOeH(lnk.sdaOeH), .sdaOutD(lnk.sdaOutD), .sdaOeD(lnk.sdaOeD), .scl(lnk.scl),
		.sda(lnk.sda));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic lwait(input int n);
		repeat (n) @(posedge linkClk);
		tick(1);
	endtask : lwait
	task automatic bus(input logic rd, input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] wd);
		cmdRead = rd;
		cmdDev = dev;
		cmdPtr = ptr;
		cmdData = wd;
		cmdValid = 1'b1;
		tick(1);
		cmdValid = 1'b0;
		check(8'(busy), 8'h01);
		for (int i = 0; i < 20000 && done !== 1'b1; i++) tick(1);
		check(8'(done), 8'h01);
		check(8'(busy), 8'h00);
	endtask : bus
	task automatic rdChk(input logic [6:0] dev, input logic [7:0] ptr, input logic nak,
		input logic [7:0] exp);
		bus(1'b1, dev, ptr, 8'h00);
		check(8'(ackErr), 8'(nak));
		if (!nak) check(rdData, exp);
	endtask : rdChk
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_init();
		rdChk(DIA, CSB, 1'b1, 8'h00);
		tick(5000);
		check(8'(laserOn), 8'h01);
		rdChk(DIA, CSB, 1'b0, 8'h00);
		rdChk(mcs_pkg::ID_ADDR, 8'h00, 1'b0, 8'h00);
	endtask : t_init
	task automatic t_soft();
		bus(1'b0, DIA, CSB, 8'hFF);
		check(8'(ackErr), 8'h00);
		check(8'(laserOn), 8'h00);
		rdChk(DIA, CSB, 1'b0, 8'h41);
		bus(1'b0, DIA, CSB, 8'h00);
		check(8'(laserOn), 8'h01);
		rdChk(DIA, CSB, 1'b0, 8'h01);
	endtask : t_soft
	task automatic t_hw();
		hwDisable = 1'b1;
		lwait(8);
		check(8'(laserOn), 8'h00);
		tick(420);
		hwDisable = 1'b0;
		lwait(8);
		check(8'(laserOn), 8'h01);
		hwDisable = 1'b1;
		tick(20);
		check(8'(lnk.txDisable), 8'h00);
		tick(GAP_T);
		check(8'(lnk.txDisable), 8'h01);
		tick(420);
		hwDisable = 1'b0;
		lwait(8);
	endtask : t_hw
	task automatic t_los();
		sigPresent = 1'b0;
		lwait(8);
		check(8'(lnk.rxLos), 8'h01);
		tick(3);
		check(8'(modLos), 8'h01);
		rdChk(DIA, CSB, 1'b0, 8'h03);
		sigPresent = 1'b1;
		lwait(8);
		check(8'(lnk.rxLos), 8'h00);
		rdChk(DIA, CSB, 1'b0, 8'h01);
	endtask : t_los
	task automatic t_fault();
		laserFault = 1'b1;
		lwait(8);
		check(8'(lnk.txFault), 8'h01);
		check(8'(laserOn), 8'h00);
		rdChk(DIA, CSB, 1'b0, 8'h05);
		check(8'(modFault), 8'h01);
		laserFault = 1'b0;
		hwDisable = 1'b1;
		tick(600);
		hwDisable = 1'b0;
		lwait(8);
		check(8'(lnk.txFault), 8'h00);
		check(8'(laserOn), 8'h01);
		rdChk(DIA, CSB, 1'b0, 8'h01);
	endtask : t_fault
	initial begin
		tick(12);
		rst_n = 1'b1;
		t_init();
		t_soft();
		t_hw();
		t_los();
		t_fault();
		wrap_up();
	end
	initial begin
		repeat (80000) @(posedge mclk);
		miscompares++;
		wrap_up();
	end
endmodule : module_control_status_timing_tb
